// [src/pcr_pkg.sv]
`default_nettype none
package pcr_pkg;
	// Byte offsets of the bank
	localparam logic [7:0] OFS_STEP_LO   = 8'h14;
	localparam logic [7:0] OFS_DELTA     = 8'h15;
	localparam logic [7:0] OFS_STEP_HI   = 8'h16;
	localparam logic [7:0] OFS_PERIOD_LO = 8'h17;
	localparam logic [7:0] OFS_LOOP      = 8'h18;
	localparam logic [7:0] OFS_PUMP      = 8'h19;
	localparam logic [7:0] OFS_REFDIV    = 8'h1A;
	localparam logic [7:0] OFS_OUTDIV    = 8'h1B;
	localparam logic [7:0] OFS_OPCTL     = 8'h1C;
	// Power-up defaults
	localparam logic [7:0] RST_STEP_LO   = 8'h00;
	localparam logic [7:0] RST_DELTA     = 8'h00;
	localparam logic [7:0] RST_STEP_HI   = 8'h00;
	localparam logic [7:0] RST_PERIOD_LO = 8'h00;
	localparam logic [7:0] RST_LOOP      = 8'h0E;
	localparam logic [7:0] RST_PUMP      = 8'h14;
	localparam logic [7:0] RST_REFDIV    = 8'h19;
	localparam logic [7:0] RST_OUTDIV    = 8'h43;
	localparam logic [7:0] RST_OPCTL     = 8'h3F;
	// Field positions (lowest bit of each field)
	localparam int POS_PERIOD_HI = 6;
	localparam int POS_SPREAD_EN = 5;
	localparam int POS_FILTER    = 1;
	localparam int POS_SMALL_RES = 0;
	localparam int POS_PUMP      = 1;
	localparam int POS_BIAS      = 0;
	localparam int POS_DOUBLER   = 7;
	localparam int POS_DIV_ONE   = 6;
	localparam int POS_DIV_TWO   = 5;
	localparam int POS_REF_DIV   = 0;
	localparam int POS_OD_THREE  = 4;
	localparam int POS_OD_FOUR   = 0;
	localparam int POS_HIRES     = 7;
	localparam int POS_REF_SRC   = 6;
	localparam int POS_RUN_A     = 1;
	localparam int POS_LOCK_A    = 0;
	localparam int POS_RUN_B     = 3;
	localparam int POS_LOCK_B    = 2;
	localparam int POS_RUN_C     = 5;
	localparam int POS_LOCK_C    = 4;
	// Shift applied in high-resolution spread mode
	localparam int HIRES_SHIFT   = 4;
endpackage : pcr_pkg
`default_nettype wire

// [src/pcr_config_bank.sv]
// Behaviour
// - 16-bit spread step, bytes 14h/16h, reset zero
// - 8-bit step delta at 15h, reset zero
// - 10-bit period from 17h and 18h[7:6]
// - 18h bit5 enables spread modulation
// - Loop filter resistor bits, reset 01110
// - Seven charge-pump scale bits, x2,/24 set
// - 19h bit0 picks 10 or 20 uA
// - 1Ah bit7 enables reference doubler
// - 1Ah bits6,5 bypass divide one, two
// - 5-bit reference divider, reset 11001
// - Output dividers three/four at 1Bh
// - 1Ch bit7 shifts spread by four
// - 1Ch bit6 picks crystal or divider
// - Run and lock bits, reset one
`timescale 1ns/100ps
`default_nettype none
module pcr_config_bank
	import pcr_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_rd_i,
	output var  logic [7:0]  reg_rdata_o,
	output var  logic        reg_hit_o,
	output var  logic [15:0] synth_b_spread_step_o,
	output var  logic [19:0] synth_b_spread_step_eff_o,
	output var  logic [7:0]  synth_b_spread_step_delta_o,
	output var  logic [9:0]  synth_b_spread_period_o,
	output var  logic        synth_b_spread_enable_o,
	output var  logic [3:0]  filter_res_select_o,
	output var  logic        filter_res_smallest_only_o,
	output var  logic [6:0]  pump_scale_o,
	output var  logic        bias_current_select_o,
	output var  logic        ref_path_doubler_o,
	output var  logic        ref_bypass_div_one_o,
	output var  logic        ref_bypass_div_two_o,
	output var  logic [4:0]  ref_divider_value_o,
	output var  logic [3:0]  output_divider_three_o,
	output var  logic [3:0]  output_divider_four_o,
	output var  logic        spread_high_resolution_o,
	output var  logic        synth_b_ref_source_o,
	output var  logic [2:0]  synth_run_o,
	output var  logic [2:0]  synth_lock_use_o
);

	logic [7:0]  step_lo_reg;
	logic [7:0]  delta_reg;
	logic [7:0]  step_hi_reg;
	logic [7:0]  period_lo_reg;
	logic [7:0]  loop_reg;
	logic [7:0]  pump_reg;
	logic [7:0]  refdiv_reg;
	logic [7:0]  outdiv_reg;
	logic [7:0]  opctl_reg;
	logic [7:0]  rdata_reg;
	logic [19:0] step_eff_reg;
	logic [7:0]  rdata_next;
	logic        hit_next;

	// Byte writes; unmapped addresses are ignored
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			step_lo_reg   <= RST_STEP_LO;
			delta_reg     <= RST_DELTA;
			step_hi_reg   <= RST_STEP_HI;
			period_lo_reg <= RST_PERIOD_LO;
			loop_reg      <= RST_LOOP;
			pump_reg      <= RST_PUMP;
			refdiv_reg    <= RST_REFDIV;
			outdiv_reg    <= RST_OUTDIV;
			opctl_reg     <= RST_OPCTL;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				OFS_STEP_LO:   step_lo_reg   <= reg_wdata_i;
				OFS_DELTA:     delta_reg     <= reg_wdata_i;
				OFS_STEP_HI:   step_hi_reg   <= reg_wdata_i;
				OFS_PERIOD_LO: period_lo_reg <= reg_wdata_i;
				OFS_LOOP:      loop_reg      <= reg_wdata_i;
				OFS_PUMP:      pump_reg      <= reg_wdata_i;
				OFS_REFDIV:    refdiv_reg    <= reg_wdata_i;
				OFS_OUTDIV:    outdiv_reg    <= reg_wdata_i;
				OFS_OPCTL:     opctl_reg     <= reg_wdata_i;
				default:       ;
			endcase
		end
	end

	// Read multiplexer; unmapped addresses answer zero
	always_comb
	begin
		rdata_next = 8'h00;
		hit_next   = 1'b1;
		case (reg_addr_i)
			OFS_STEP_LO:   rdata_next = step_lo_reg;
			OFS_DELTA:     rdata_next = delta_reg;
			OFS_STEP_HI:   rdata_next = step_hi_reg;
			OFS_PERIOD_LO: rdata_next = period_lo_reg;
			OFS_LOOP:      rdata_next = loop_reg;
			OFS_PUMP:      rdata_next = pump_reg;
			OFS_REFDIV:    rdata_next = refdiv_reg;
			OFS_OUTDIV:    rdata_next = outdiv_reg;
			OFS_OPCTL:     rdata_next = opctl_reg;
			default:       hit_next   = 1'b0;
		endcase
	end

	// Read data held until the next read strobe
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_reg <= 8'h00;
		else if (reg_rd_i)
			rdata_reg <= rdata_next;
	end

	// Spread step as seen by the modulator, shifted in high-resolution mode
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			step_eff_reg <= 20'h00000;
		else if (opctl_reg[POS_HIRES])
			step_eff_reg <= {step_hi_reg, step_lo_reg, 4'h0};
		else
			step_eff_reg <= {4'h0, step_hi_reg, step_lo_reg};
	end

	// Register interface outputs
	assign reg_rdata_o = rdata_reg;
	assign reg_hit_o   = hit_next;

	// Spread modulation fields
	assign synth_b_spread_step_o       = {step_hi_reg, step_lo_reg};
	assign synth_b_spread_step_eff_o   = step_eff_reg;
	assign synth_b_spread_step_delta_o = delta_reg;
	assign synth_b_spread_period_o     = {loop_reg[POS_PERIOD_HI +: 2], period_lo_reg};
	assign synth_b_spread_enable_o     = loop_reg[POS_SPREAD_EN];

	// Loop filter, charge pump and bias
	assign filter_res_select_o        = loop_reg[POS_FILTER +: 4];
	assign filter_res_smallest_only_o = loop_reg[POS_SMALL_RES];
	assign pump_scale_o               = pump_reg[POS_PUMP +: 7];
	assign bias_current_select_o      = pump_reg[POS_BIAS];

	// Reference path
	assign ref_path_doubler_o   = refdiv_reg[POS_DOUBLER];
	assign ref_bypass_div_one_o = refdiv_reg[POS_DIV_ONE];
	assign ref_bypass_div_two_o = refdiv_reg[POS_DIV_TWO];
	assign ref_divider_value_o  = refdiv_reg[POS_REF_DIV +: 5];

	// Output dividers
	assign output_divider_three_o = outdiv_reg[POS_OD_THREE +: 4];
	assign output_divider_four_o  = outdiv_reg[POS_OD_FOUR +: 4];

	// Operation control
	assign spread_high_resolution_o = opctl_reg[POS_HIRES];
	assign synth_b_ref_source_o     = opctl_reg[POS_REF_SRC];
	assign synth_run_o      = {opctl_reg[POS_RUN_C], opctl_reg[POS_RUN_B], opctl_reg[POS_RUN_A]};
	assign synth_lock_use_o = {opctl_reg[POS_LOCK_C], opctl_reg[POS_LOCK_B], opctl_reg[POS_LOCK_A]};

	// Step bytes follow their writes
	step_bytes_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_STEP_HI)
		|=> synth_b_spread_step_o[15:8] == $past(reg_wdata_i))
		else $error("step high byte not stored");

	step_low_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_STEP_LO)
		|=> synth_b_spread_step_o[7:0] == $past(reg_wdata_i) && $stable(synth_b_spread_step_o[15:8]))
		else $error("step low byte not stored");

	delta_write_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_DELTA) |=> synth_b_spread_step_delta_o == $past(reg_wdata_i))
		else $error("step delta not stored");

	period_high_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_LOOP)
		|=> synth_b_spread_period_o[9:8] == $past(reg_wdata_i[7:6])
			&& synth_b_spread_enable_o == $past(reg_wdata_i[5])
			&& filter_res_select_o == $past(reg_wdata_i[4:1]))
		else $error("period high, enable or filter wrong");

	pump_bias_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_PUMP)
		|=> pump_scale_o == $past(reg_wdata_i[7:1]) && bias_current_select_o == $past(reg_wdata_i[0]))
		else $error("pump or bias field wrong");

	ref_path_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_REFDIV)
		|=> ref_path_doubler_o == $past(reg_wdata_i[7]) && ref_bypass_div_one_o == $past(reg_wdata_i[6])
			&& ref_bypass_div_two_o == $past(reg_wdata_i[5]) && ref_divider_value_o == $past(reg_wdata_i[4:0]))
		else $error("reference path field wrong");

	out_div_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_OUTDIV)
		|=> output_divider_three_o == $past(reg_wdata_i[7:4]) && output_divider_four_o == $past(reg_wdata_i[3:0]))
		else $error("output divider nibble wrong");

	run_lock_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_OPCTL)
		|=> synth_run_o == {$past(reg_wdata_i[5]), $past(reg_wdata_i[3]), $past(reg_wdata_i[1])}
			&& synth_lock_use_o == {$past(reg_wdata_i[4]), $past(reg_wdata_i[2]), $past(reg_wdata_i[0])}
			&& synth_b_ref_source_o == $past(reg_wdata_i[6]))
		else $error("run or lock bits wrong");

	hires_shift_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		spread_high_resolution_o && $stable(synth_b_spread_step_o)
		|=> synth_b_spread_step_eff_o == {$past(synth_b_spread_step_o), 4'h0})
		else $error("high resolution shift missing");

	normal_res_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		!spread_high_resolution_o |=> synth_b_spread_step_eff_o == {4'h0, $past(synth_b_spread_step_o)})
		else $error("normal resolution step wrong");

	read_back_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_hit_o) ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i))
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("read did not return last write");

	unmapped_read_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_rd_i && !reg_hit_o |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");

	hold_idle_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		!reg_wr_i && !reg_rd_i |=> $stable(reg_rdata_o) && $stable(synth_run_o) && $stable(pump_scale_o))
		else $error("state changed without access");

	// Low period byte lands without touching the high bits
	period_low_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_PERIOD_LO)
		|=> synth_b_spread_period_o[7:0] == $past(reg_wdata_i) && $stable(synth_b_spread_period_o[9:8]))
		else $error("period low byte not stored");

	// Spread enable follows its own bit
	spread_enable_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_LOOP)
		|=> synth_b_spread_enable_o == $past(reg_wdata_i[POS_SPREAD_EN]))
		else $error("spread enable not stored");

	// Smallest resistor alone follows bit zero
	filter_only_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_LOOP)
		|=> filter_res_smallest_only_o == $past(reg_wdata_i[POS_SMALL_RES]))
		else $error("smallest resistor bit not stored");

	// Reference source follows its bit
	ref_source_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && (reg_addr_i == OFS_OPCTL)
		|=> synth_b_ref_source_o == $past(reg_wdata_i[POS_REF_SRC]))
		else $error("reference source not stored");

	// Writes outside the bank leave the fields alone
	unmapped_write_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_wr_i && !reg_hit_o
		|=> $stable(synth_b_spread_step_o) && $stable(synth_b_spread_period_o) && $stable(pump_scale_o)
			&& $stable(ref_divider_value_o) && $stable(synth_run_o) && $stable(synth_b_spread_step_delta_o))
		else $error("unmapped write changed a field");

	// Hit flag covers exactly the mapped window
	hit_decode_a: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		reg_hit_o == (reg_addr_i >= OFS_STEP_LO && reg_addr_i <= OFS_OPCTL))
		else $error("hit flag wrong");

	// Power-up defaults seen at the first edge after reset
	reset_spread_a: assert property (
		@(posedge clock_i)
		$rose(rst_n_i) |-> synth_b_spread_step_o == {RST_STEP_HI, RST_STEP_LO}
			&& synth_b_spread_step_delta_o == RST_DELTA
			&& synth_b_spread_period_o == {RST_LOOP[POS_PERIOD_HI +: 2], RST_PERIOD_LO}
			&& synth_b_spread_step_eff_o == 20'h00000 && reg_rdata_o == 8'h00)
		else $error("spread defaults wrong after reset");

	reset_filter_a: assert property (
		@(posedge clock_i)
		$rose(rst_n_i)
		|-> {synth_b_spread_enable_o, filter_res_select_o, filter_res_smallest_only_o} == RST_LOOP[5:0])
		else $error("loop filter default wrong");

	reset_pump_a: assert property (
		@(posedge clock_i)
		$rose(rst_n_i) |-> {pump_scale_o, bias_current_select_o} == RST_PUMP)
		else $error("charge pump default wrong");

	reset_refdiv_a: assert property (
		@(posedge clock_i)
		$rose(rst_n_i)
		|-> {ref_path_doubler_o, ref_bypass_div_one_o, ref_bypass_div_two_o, ref_divider_value_o} == RST_REFDIV)
		else $error("reference divider default wrong");

	reset_outdiv_a: assert property (
		@(posedge clock_i)
		$rose(rst_n_i) |-> {output_divider_three_o, output_divider_four_o} == RST_OUTDIV)
		else $error("output divider default wrong");

	reset_control_a: assert property (
		@(posedge clock_i)
		$rose(rst_n_i) |-> {spread_high_resolution_o, synth_b_ref_source_o} == RST_OPCTL[7:6]
			&& synth_run_o == {RST_OPCTL[POS_RUN_C], RST_OPCTL[POS_RUN_B], RST_OPCTL[POS_RUN_A]}
			&& synth_lock_use_o == {RST_OPCTL[POS_LOCK_C], RST_OPCTL[POS_LOCK_B], RST_OPCTL[POS_LOCK_A]})
		else $error("operation control default wrong");

endmodule // pcr_config_bank
`default_nettype wire

// [testbench/pll2_config_register_bank_test.sv]
`timescale 1ns/100ps
`default_nettype none
module pll2_config_register_bank_test
	import pcr_pkg::*;
();
	logic        clock_i, rst_n_i, reg_wr_i, reg_rd_i, reg_hit_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, synth_b_spread_step_delta_o;
	logic [15:0] synth_b_spread_step_o;
	logic [19:0] synth_b_spread_step_eff_o;
	logic [9:0]  synth_b_spread_period_o;
	logic        synth_b_spread_enable_o, filter_res_smallest_only_o, bias_current_select_o;
	logic        ref_path_doubler_o, ref_bypass_div_one_o, ref_bypass_div_two_o;
	logic        spread_high_resolution_o, synth_b_ref_source_o;
	logic [3:0]  filter_res_select_o, output_divider_three_o, output_divider_four_o;
	logic [6:0]  pump_scale_o;
	logic [4:0]  ref_divider_value_o;
	logic [2:0]  synth_run_o, synth_lock_use_o;
	int          n_fail;
	int          check_count;
	// Power-up bytes and a test pattern, offsets 14h upwards
	localparam logic [7:0] DFT [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h14, 8'h19, 8'h43, 8'h3F};
	localparam logic [7:0] PAT [9] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'hA9, 8'h81, 8'hE6, 8'h9E, 8'hC0};

	pcr_config_bank u_dut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
		.reg_rdata_o, .reg_hit_o, .synth_b_spread_step_o, .synth_b_spread_step_eff_o,
		.synth_b_spread_step_delta_o, .synth_b_spread_period_o, .synth_b_spread_enable_o,
		.filter_res_select_o, .filter_res_smallest_only_o, .pump_scale_o, .bias_current_select_o,
		.ref_path_doubler_o, .ref_bypass_div_one_o, .ref_bypass_div_two_o, .ref_divider_value_o,
		.output_divider_three_o, .output_divider_four_o, .spread_high_resolution_o,
		.synth_b_ref_source_o, .synth_run_o, .synth_lock_use_o);

	// Free-running clock
	always #5 clock_i = ~clock_i;

	// Compare and count
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// One write, strobe dropped a cycle before returning
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clock_i);
		reg_wr_i = 1'b0;
		@(negedge clock_i);
	endtask

	// One read, data holds until the next read
	task automatic rd(input logic [7:0] a);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clock_i);
		reg_rd_i = 1'b0;
		@(negedge clock_i);
	endtask

	// Defaults on reads and on every field
	task automatic t_reset;
		for (int i = 0; i < 9; i++)
		begin
			rd(8'h14 + 8'(i));
			check("read byte", 20'(reg_rdata_o), 20'(DFT[i]));
		end
		check("step", 20'(synth_b_spread_step_o), 20'h0);
		check("delta", 20'(synth_b_spread_step_delta_o), 20'h0);
		check("period", 20'(synth_b_spread_period_o), 20'h0);
		check("enable", 20'(synth_b_spread_enable_o), 20'h0);
		check("filter", 20'({filter_res_select_o, filter_res_smallest_only_o}), 20'h0E);
		check("pump", 20'(pump_scale_o), 20'h0A);
		check("bias", 20'(bias_current_select_o), 20'h0);
		check("doubler", 20'(ref_path_doubler_o), 20'h0);
		check("bypass", 20'({ref_bypass_div_one_o, ref_bypass_div_two_o}), 20'h0);
		check("ref div", 20'(ref_divider_value_o), 20'h19);
		check("out div", 20'({output_divider_three_o, output_divider_four_o}), 20'h43);
		check("hires", 20'(spread_high_resolution_o), 20'h0);
		check("step eff", synth_b_spread_step_eff_o, 20'h0);
		check("source", 20'(synth_b_ref_source_o), 20'h0);
		check("run lock", 20'({synth_run_o, synth_lock_use_o}), 20'h3F);
		$display("reset test done");
	endtask

	// Back-to-back writes of all bytes, then fields and read-back
	task automatic t_fields;
		for (int i = 0; i < 9; i++)
		begin
			reg_wr_i = 1'b1;
			reg_addr_i = 8'h14 + 8'(i);
			reg_wdata_i = PAT[i];
			@(negedge clock_i);
		end
		reg_wr_i = 1'b0;
		@(negedge clock_i);
		check("step", 20'(synth_b_spread_step_o), 20'h5AA5);
		check("delta", 20'(synth_b_spread_step_delta_o), 20'h3C);
		check("period", 20'(synth_b_spread_period_o), 20'h2C3);
		check("enable", 20'(synth_b_spread_enable_o), 20'h1);
		check("filter", 20'({filter_res_select_o, filter_res_smallest_only_o}), 20'h09);
		check("pump", 20'(pump_scale_o), 20'h40);
		check("bias", 20'(bias_current_select_o), 20'h1);
		check("doubler", 20'(ref_path_doubler_o), 20'h1);
		check("bypass", 20'({ref_bypass_div_one_o, ref_bypass_div_two_o}), 20'h3);
		check("ref div", 20'(ref_divider_value_o), 20'h06);
		check("out div", 20'({output_divider_three_o, output_divider_four_o}), 20'h9E);
		check("step eff", synth_b_spread_step_eff_o, 20'h5AA50);
		check("hires", 20'(spread_high_resolution_o), 20'h1);
		check("source", 20'(synth_b_ref_source_o), 20'h1);
		check("run lock", 20'({synth_run_o, synth_lock_use_o}), 20'h00);
		for (int i = 0; i < 9; i++)
		begin
			rd(8'h14 + 8'(i));
			check("read byte", 20'(reg_rdata_o), 20'(PAT[i]));
		end
		wr(8'h1C, 8'h3F);
		check("step eff", synth_b_spread_step_eff_o, 20'h05AA5);
		check("run lock", 20'({synth_run_o, synth_lock_use_o}), 20'h3F);
		$display("field test done");
	endtask

	// Unmapped places, read and write together, reset in mid-run
	task automatic t_edge;
		reg_addr_i = 8'h13;
		#1 check("hit", 20'(reg_hit_o), 20'h0);
		@(negedge clock_i);
		reg_addr_i = 8'h1C;
		#1 check("hit", 20'(reg_hit_o), 20'h1);
		@(negedge clock_i);
		wr(8'h13, 8'hFF);
		wr(8'h1D, 8'hFF);
		check("step kept", 20'(synth_b_spread_step_o), 20'h5AA5);
		check("run lock kept", 20'({synth_run_o, synth_lock_use_o}), 20'h3F);
		rd(8'h1D);
		check("unmapped read", 20'(reg_rdata_o), 20'h0);
		rd(8'h14);
		check("read byte", 20'(reg_rdata_o), 20'hA5);
		reg_rd_i = 1'b1;
		reg_wr_i = 1'b1;
		reg_addr_i = 8'h15;
		reg_wdata_i = 8'h77;
		@(negedge clock_i);
		reg_rd_i = 1'b0;
		reg_wr_i = 1'b0;
		check("old on collide", 20'(reg_rdata_o), 20'h3C);
		check("delta", 20'(synth_b_spread_step_delta_o), 20'h77);
		@(negedge clock_i);
		reg_wr_i = 1'b1;
		reg_addr_i = 8'h17;
		reg_wdata_i = 8'h5C;
		@(negedge clock_i);
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b1;
		@(negedge clock_i);
		reg_rd_i = 1'b0;
		check("read after write", 20'(reg_rdata_o), 20'h5C);
		@(negedge clock_i);
		rst_n_i = 1'b0;
		@(negedge clock_i);
		check("period in reset", 20'(synth_b_spread_period_o), 20'h0);
		rst_n_i = 1'b1;
		@(negedge clock_i);
		t_reset();
		$display("edge test done");
	endtask

	// Counts, verdict and end of run
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		clock_i = 1'b0;
		rst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		repeat (10) @(negedge clock_i);
		rst_n_i = 1'b1;
		@(negedge clock_i);
		t_reset();
		t_fields();
		t_edge();
		give_verdict();
	end
endmodule // pll2_config_register_bank_test
`default_nettype wire
